//--- verilog/disk_iface_consts.svh
// Constants for the disk drive control interface.
// Assumes a 40 MHz clock and 32-bit AXI4-Lite register access.
`ifndef DISK_IFACE_CONSTS_SVH
`define DISK_IFACE_CONSTS_SVH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_CYL       8'h08
`define REG_INDEX_DIV 8'h0c
// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define CTRL_SUPPLY_OK 0
`define CTRL_RECAL     1
`define CTRL_SETTLE_OK 2
`define CTRL_ADDR_LO   4
`define CTRL_RESET     32'h0000_0000
`define START_CYL      16'h0005
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_MHZ          40
`define SEEK_DROP_NS     500
`define SEEK_DROP_CYC    ((`SEEK_DROP_NS * `CLK_MHZ) / 1000)
`define INDEX_PERIOD_US  16700
`define INDEX_PERIOD_CYC (`INDEX_PERIOD_US * `CLK_MHZ)
`define READY_DELAY_S    15
`define READY_DELAY_CYC  (`READY_DELAY_S * `CLK_MHZ * 1000000)
`define SETTLE_CYC       16
`define INDEX_WIDTH_CYC  8
`define CYL_COUNT        306
`endif

//--- verilog/disk_iface_pkg.sv
// Types for the disk drive control interface.
// Assumes the constants header is included by the design file.
package disk_iface_pkg;
  typedef enum logic [2:0] {
    ST_POWER_UP,
    ST_RECAL,
    ST_WAIT_READY,
    ST_IDLE,
    ST_STEPPING,
    ST_SETTLE
  } drive_state_e;
endpackage : disk_iface_pkg

//--- verilog/disk_iface.sv
// Drive-side logic of the disk control interface with AXI4-Lite access.
// Assumes host pins are synchronous to clock and active high internally.
`timescale 1ns/1ps
`include "disk_iface_consts.svh"

// Function
// - Two head-select lines give binary head number, line zero least.
// - Motion begins on the trailing edge of each step pulse.
// - Buffered seek moves one cylinder per step pulse received.
// - Excess steps stop heads at the last cylinder without fault.
// - Direction false moves outward, true moves inward.
// - Unselected drive ignores inputs and releases all status outputs.
// - Seek complete rises after settling, falls within 500 ns of step.
// - Seek complete held false during recalibration after power events.
// - Track zero true only while heads sit on track 0.
// - Fault blocks writing; set on low supply and until recalibration.
// - Index pulses once per revolution; rising edge marks track start.
// - Write needs ready and seek complete; read needs ready only; steps taken in idle, stepping and settle.
// - Power on raises track zero, seek complete, then ready.
// - Drive-selected output only when matching select line is active.
// - Rising write data edge writes one flux reversal under write gate.
// - Each read flux reversal is a rising edge on read data.
// - Write gate active low: writes when low, reads and steps when high.
module disk_iface #(
  parameter int unsigned READY_CYC = `READY_DELAY_CYC,
  parameter int unsigned INDEX_CYC = `INDEX_PERIOD_CYC,
  parameter int unsigned CYLS      = `CYL_COUNT
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic [3:0]  drive_sel,
  input  wire logic [1:0]  head_sel,
  input  wire logic        step,
  input  wire logic        dir_in,
  input  wire logic        write_gate_n,
  input  wire logic        wdata,
  input  wire logic        media_flux,
  output logic             seek_done,
  output logic             track_zero,
  output logic             fault,
  output logic             index_pulse,
  output logic             ready,
  output logic             drive_selected,
  output logic             rdata,
  output logic             flux_write,
  output logic [1:0]       head_active,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `REG_CTRL) || (a == `REG_STATUS) ||
              (a == `REG_CYL) || (a == `REG_INDEX_DIV);
  endfunction : reg_hit

  disk_iface_pkg::drive_state_e state_q;
  logic [31:0] ctrl_q;
  logic [15:0] cyl_q;
  logic [15:0] pending_q;
  logic        dir_q;
  logic [31:0] ready_cnt_q;
  logic [31:0] index_cnt_q;
  logic [7:0]  settle_q;
  logic        step_q;
  logic        wdata_q;
  logic        flux_q;
  logic        fault_q;
  logic        sel_now;
  logic        trail;
  logic        writing;
  logic        at_limit;

  // Select line matching the drive address gates the step input and all pin outputs.
  assign sel_now = drive_sel[ctrl_q[`CTRL_ADDR_LO +: 2]];
  assign trail   = step_q && !step;
  // Write gate is active low.
  assign writing = !write_gate_n;

  // ---------------------------------------------------------------
  // Edge capture
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      step_q  <= 1'b0;
      wdata_q <= 1'b0;
      flux_q  <= 1'b0;
    end else if (clk_en) begin
      step_q  <= step && sel_now;
      wdata_q <= wdata;
      flux_q  <= media_flux;
    end
  end

  // ---------------------------------------------------------------
  // Seek, recalibration and power-on sequence
  // ---------------------------------------------------------------
  assign at_limit = dir_q ? (cyl_q == 16'(CYLS - 1)) : (cyl_q == 16'h0000);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q     <= disk_iface_pkg::ST_POWER_UP;
      cyl_q       <= `START_CYL;
      pending_q   <= 16'h0000;
      dir_q       <= 1'b0;
      ready_cnt_q <= 32'h0000_0000;
      settle_q    <= 8'h00;
    end else if (clk_en) begin
      case (state_q)
        disk_iface_pkg::ST_POWER_UP: begin
          dir_q <= 1'b0;
          state_q <= disk_iface_pkg::ST_RECAL;
        end
        disk_iface_pkg::ST_RECAL: begin
          if (cyl_q == 16'h0000) begin
            state_q <= disk_iface_pkg::ST_WAIT_READY;
          end else begin
            cyl_q <= cyl_q - 16'h0001;
          end
        end
        disk_iface_pkg::ST_WAIT_READY: begin
          if (ready_cnt_q >= READY_CYC) begin
            state_q <= disk_iface_pkg::ST_IDLE;
          end else begin
            ready_cnt_q <= ready_cnt_q + 32'h0000_0001;
          end
        end
        disk_iface_pkg::ST_IDLE: begin
          if (ctrl_q[`CTRL_RECAL] || fault_q) begin
            cyl_q   <= cyl_q;
            state_q <= disk_iface_pkg::ST_RECAL;
          end else if (trail && !writing) begin
            dir_q     <= dir_in;
            pending_q <= 16'h0001;
            state_q   <= disk_iface_pkg::ST_STEPPING;
          end
        end
        disk_iface_pkg::ST_STEPPING: begin
          if (trail && !writing) begin
            pending_q <= pending_q + 16'h0001;
          end else if (pending_q == 16'h0000) begin
            settle_q <= 8'h00;
            state_q  <= disk_iface_pkg::ST_SETTLE;
          end else begin
            pending_q <= pending_q - 16'h0001;
            if (!at_limit) begin
              cyl_q <= dir_q ? cyl_q + 16'h0001 : cyl_q - 16'h0001;
            end
          end
        end
        disk_iface_pkg::ST_SETTLE: begin
          if (trail && !writing) begin
            pending_q <= 16'h0001;
            state_q   <= disk_iface_pkg::ST_STEPPING;
          end else if (settle_q >= 8'(`SETTLE_CYC) &&
                       ctrl_q[`CTRL_SETTLE_OK]) begin
            state_q <= disk_iface_pkg::ST_IDLE;
          end else if (settle_q < 8'(`SETTLE_CYC)) begin
            settle_q <= settle_q + 8'h01;
          end
        end
        default: state_q <= disk_iface_pkg::ST_POWER_UP;
      endcase
    end
  end

  // Fault stands from reset until recalibration finishes, and on low supply.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      fault_q <= 1'b1;
    end else if (clk_en) begin
      if (!ctrl_q[`CTRL_SUPPLY_OK]) begin
        fault_q <= 1'b1;
      end else if (state_q == disk_iface_pkg::ST_RECAL &&
                   cyl_q == 16'h0000) begin
        fault_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Index generator
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      index_cnt_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (index_cnt_q >= INDEX_CYC - 1) begin
        index_cnt_q <= 32'h0000_0000;
      end else begin
        index_cnt_q <= index_cnt_q + 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin outputs, all gated by select
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      seek_done      <= 1'b0;
      track_zero     <= 1'b0;
      fault          <= 1'b0;
      index_pulse    <= 1'b0;
      ready          <= 1'b0;
      drive_selected <= 1'b0;
      rdata          <= 1'b0;
      flux_write     <= 1'b0;
      head_active    <= 2'h0;
    end else if (clk_en) begin
      // Seek complete drops one clock after the trailing edge, well inside 500 ns.
      seek_done <= sel_now && !trail &&
                   (state_q == disk_iface_pkg::ST_IDLE ||
                    state_q == disk_iface_pkg::ST_WAIT_READY);
      track_zero <= sel_now && cyl_q == 16'h0000 &&
                    state_q != disk_iface_pkg::ST_POWER_UP;
      fault <= sel_now && fault_q;
      index_pulse <= sel_now &&
                     index_cnt_q < 32'(`INDEX_WIDTH_CYC);
      ready <= sel_now && state_q != disk_iface_pkg::ST_POWER_UP &&
               state_q != disk_iface_pkg::ST_RECAL &&
               state_q != disk_iface_pkg::ST_WAIT_READY;
      drive_selected <= sel_now;
      if (sel_now) begin
        head_active <= head_sel;
      end
      flux_write <= sel_now && writing && ready && seek_done &&
                    !fault_q && wdata && !wdata_q;
      rdata <= sel_now && !writing && ready &&
               media_flux && !flux_q;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic        aw_got_q;
  logic        w_got_q;
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_q          <= 8'h00;
      w_q           <= 32'h0000_0000;
      ws_q          <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      ctrl_q        <= `CTRL_RESET;
    end else if (clk_en) begin
      s_axi_awready <= !aw_got_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_got_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        aw_q     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        w_q     <= s_axi_wdata;
        ws_q    <= s_axi_wstrb;
      end
      // Recalibrate request is a one-shot once the sequencer takes it.
      // Cleared first so that a software request in the same cycle wins.
      if (state_q == disk_iface_pkg::ST_RECAL) begin
        ctrl_q[`CTRL_RECAL] <= 1'b0;
      end
      if (aw_got_q && w_got_q && !s_axi_bvalid) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_hit(aw_q) ? 2'h0 : 2'h2;
        if (aw_q == `REG_CTRL) begin
          for (int i = 0; i < 4; i++) begin
            if (ws_q[i]) begin
              ctrl_q[i*8 +: 8] <= w_q[i*8 +: 8];
            end
          end
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= reg_hit(s_axi_araddr) ? 2'h0 : 2'h2;
        case (s_axi_araddr)
          `REG_CTRL:      s_axi_rdata <= ctrl_q;
          `REG_STATUS:    s_axi_rdata <= {23'h0, state_q, fault_q,
                                          drive_selected, ready,
                                          track_zero, seek_done, sel_now};
          `REG_CYL:       s_axi_rdata <= {16'h0000, cyl_q};
          `REG_INDEX_DIV: s_axi_rdata <= index_cnt_q;
          default:        s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_unsel_quiet;
    @(posedge clock) disable iff (!resetn)
    (clk_en && !sel_now) |=> !seek_done && !fault && !ready && !index_pulse;
  endproperty
  a_unsel_quiet: assert property (p_unsel_quiet)
    else $error("Status driven while not selected.");

  property p_seek_drop;
    @(posedge clock) disable iff (!resetn)
    (clk_en && trail) |=> !seek_done;
  endproperty
  a_seek_drop: assert property (p_seek_drop)
    else $error("Seek complete not dropped after step.");

  property p_track_zero;
    @(posedge clock) disable iff (!resetn)
    track_zero |-> $past(cyl_q) == 16'h0000;
  endproperty
  a_track_zero: assert property (p_track_zero)
    else $error("Track zero away from cylinder zero.");

  property p_no_write_fault;
    @(posedge clock) disable iff (!resetn)
    flux_write |-> !$past(fault_q);
  endproperty
  a_no_write_fault: assert property (p_no_write_fault)
    else $error("Write under fault.");

  property p_limit;
    @(posedge clock) disable iff (!resetn)
    cyl_q <= 16'(CYLS - 1);
  endproperty
  a_limit: assert property (p_limit)
    else $error("Cylinder beyond last.");

  property p_ready_order;
    @(posedge clock) disable iff (!resetn)
    $rose(ready) && $past(drive_selected) |->
      $past(track_zero) && $past(seek_done) && $past(cyl_q) == 16'h0000;
  endproperty
  a_ready_order: assert property (p_ready_order)
    else $error("Ready before track zero.");

  property p_sel_out;
    @(posedge clock) disable iff (!resetn)
    clk_en |=> drive_selected == $past(sel_now);
  endproperty
  a_sel_out: assert property (p_sel_out)
    else $error("Drive selected mismatch.");

  sequence s_write_edge;
    clk_en && writing && wdata && !wdata_q && sel_now;
  endsequence
  property p_read_gate;
    @(posedge clock) disable iff (!resetn)
    rdata |-> !$past(writing);
  endproperty
  a_read_gate: assert property (p_read_gate)
    else $error("Read data while writing.");

  property p_write_needs;
    @(posedge clock) disable iff (!resetn)
    flux_write |-> $past(ready) && $past(seek_done);
  endproperty
  a_write_needs: assert property (p_write_needs)
    else $error("Write without ready and seek complete.");

  property p_write_edge;
    @(posedge clock) disable iff (!resetn)
    s_write_edge ##0 (ready && seek_done && !fault_q) |=> flux_write;
  endproperty
  a_write_edge: assert property (p_write_edge)
    else $error("Write edge lost.");
endmodule : disk_iface

//--- tb/host_ctrl.sv
// Host controller model that drives the drive's control and write pins.
// Assumes it shares the 40 MHz clock of the drive under test.
`timescale 1ns/1ps
module host_ctrl (
  input  wire logic       clock,
  input  wire logic       seek_done,
  output logic [3:0]      drive_sel,
  output logic [1:0]      head_sel,
  output logic            step,
  output logic            dir_in,
  output logic            write_gate_n,
  output logic            wdata
);
  int late;
  initial begin
    drive_sel    = 4'h0;
    head_sel     = 2'h0;
    step         = 1'b0;
    dir_in       = 1'b0;
    write_gate_n = 1'b1;
    wdata        = 1'b0;
    late         = 0;
  end
  task automatic select(input logic [3:0] s);
    drive_sel <= s;
    @(posedge clock);
  endtask : select
  task automatic head(input logic [1:0] h);
    head_sel <= h;
    repeat (96) @(posedge clock);
  endtask : head
  // Pulses are 1 us high and 1 us low, so the drive settles and returns to idle between pulses.
  task automatic seek(input logic d, input int n, input bit wait_done);
    int k;
    k = 0;
    while (wait_done && !seek_done && k < 4000) begin
      k++;
      @(posedge clock);
    end
    if (k == 4000) late++;
    dir_in <= d;
    repeat (8) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (39) @(posedge clock);
      step <= 1'b1;
      repeat (40) @(posedge clock);
      step <= 1'b0;
      @(posedge clock);
    end
  endtask : seek
  task automatic write_flux(input int n);
    write_gate_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clock);
      wdata <= 1'b1;
      repeat (4) @(posedge clock);
      wdata <= 1'b0;
    end
    repeat (4) @(posedge clock);
    write_gate_n <= 1'b1;
    repeat (96) @(posedge clock);
  endtask : write_flux
endmodule : host_ctrl

//--- tb/tb_disk_iface.sv
// Self-checking bench for the drive-side disk interface logic.
// Assumes the host model and a 40 MHz clock; ready and index counts are shortened.
`timescale 1ns/1ps
`include "disk_iface_consts.svh"
module tb_disk_iface;
  localparam int unsigned RDY = 50;
  localparam int unsigned IDX = 100;
  localparam int unsigned CYL = 306;
  logic clock, resetn, clk_en, media_flux, step, dir_in, write_gate_n;
  logic wdata, seek_done, track_zero, fault, index_pulse, ready;
  logic drive_selected, rdata, flux_write;
  logic [3:0] drive_sel;
  logic [1:0] head_sel, head_active;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int n_fail, samples_checked, n_wr, n_rd;
  disk_iface #(.READY_CYC(RDY), .INDEX_CYC(IDX), .CYLS(CYL)) i_disk_iface (
    .clock, .resetn, .clk_en, .drive_sel, .head_sel, .step, .dir_in,
    .write_gate_n, .wdata, .media_flux, .seek_done, .track_zero, .fault,
    .index_pulse, .ready, .drive_selected, .rdata, .flux_write,
    .head_active, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  host_ctrl host (.clock, .seek_done, .drive_sel, .head_sel, .step,
    .dir_in, .write_gate_n, .wdata);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (flux_write === 1'b1) n_wr++;
    if (rdata === 1'b1) n_rd++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clock);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask : axi_rd
  task automatic settle();
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (seek_done !== 1'b1 && k < 4000);
    check(k < 4000, 1);
  endtask : settle
  task automatic t_power();
    int t, tz, ts, tr;
    tz = -1; ts = -1; tr = -1;
    host.select(4'h1);
    axi_wr(`REG_CTRL, 32'h0000_0007);
    check(rr, 2'h0);
    for (t = 0; t < 3000 && tr < 0; t++) begin
      @(posedge clock);
      if (tz < 0 && track_zero === 1'b1) tz = t;
      if (ts < 0 && seek_done === 1'b1) ts = t;
      if (tr < 0 && ready === 1'b1) tr = t;
    end
    check(tz >= 0 && tz <= ts && ts <= tr, 1);
    check({ready, fault, drive_selected}, 3'b101);
    axi_rd(`REG_CTRL);
    check(rd, 32'h0000_0005);
    axi_rd(8'h10);
    check(rr, 2'h2);
    check(rd, 32'h0);
  endtask : t_power
  task automatic t_seek();
    host.seek(1'b0, 310, 1'b1);
    settle();
    check(track_zero, 1);
    axi_rd(`REG_CYL);
    check(rd, 0);
    host.seek(1'b1, 1, 1'b1);
    repeat (`SEEK_DROP_CYC - 1) @(posedge clock);
    check(seek_done, 0);
    settle();
    check({seek_done, track_zero}, 2'b10);
    axi_rd(`REG_CYL);
    check(rd, 1);
    host.seek(1'b1, 400, 1'b1);
    settle();
    axi_rd(`REG_CYL);
    check(rd, CYL - 1);
    check(fault, 0);
  endtask : t_seek
  task automatic t_desel();
    logic any;
    any = 1'b0;
    host.select(4'h2);
    for (int k = 0; k < 2 * IDX; k++) begin
      @(posedge clock);
      any |= seek_done | track_zero | fault | index_pulse | ready;
      any |= drive_selected;
    end
    check(any, 0);
    host.seek(1'b0, 2, 1'b0);
    host.select(4'h1);
    settle();
    axi_rd(`REG_CYL);
    check(rd, CYL - 1);
  endtask : t_desel
  task automatic t_data();
    int w0, r0;
    for (int h = 0; h < 4; h++) begin
      host.head(h[1:0]);
      check(head_active, h);
    end
    w0 = n_wr;
    host.write_flux(3);
    check(n_wr - w0, 3);
    r0 = n_rd;
    for (int i = 0; i < 3; i++) begin
      media_flux <= 1'b1;
      repeat (4) @(posedge clock);
      media_flux <= 1'b0;
      repeat (4) @(posedge clock);
    end
    repeat (4) @(posedge clock);
    check(n_rd - r0, 3);
  endtask : t_data
  task automatic t_index();
    int n;
    n = 0;
    while (index_pulse !== 1'b0) @(posedge clock);
    while (index_pulse !== 1'b1 && n < 300) begin
      n++;
      @(posedge clock);
    end
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!(index_pulse === 1'b1 && n > 8) && n < 300);
    check(n, IDX);
  endtask : t_index
  task automatic t_fault();
    int w0;
    axi_wr(`REG_CTRL, 32'h0000_0004);
    repeat (4) @(posedge clock);
    check(fault, 1);
    w0 = n_wr;
    host.write_flux(2);
    check(n_wr - w0, 0);
    axi_wr(`REG_CTRL, 32'h0000_0007);
    for (int k = 0; k < 4000 && fault !== 1'b0; k++) @(posedge clock);
    check(fault, 0);
  endtask : t_fault
  initial begin
    {resetn, clk_en, media_flux} = 3'b010;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {n_fail, samples_checked, n_wr, n_rd} = '0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_power();
    t_seek();
    t_desel();
    t_data();
    t_index();
    t_fault();
    check(host.late, 0);
    conclude();
  end
  initial begin
    repeat (90000) @(posedge clock);
    n_fail++;
    conclude();
  end
endmodule : tb_disk_iface
